// ===== design/sor_output_stage.sv
// Output stage routing, alarms, start window and diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "sor_consts.svh"
module sor_output_stage #(
    parameter int unsigned START_WIN_CYC = `SOR_START_WIN_CYC,
    parameter int unsigned WDOG_CYC = `SOR_WDOG_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Nonvolatile configuration
    input wire logic [4:0] cfg_num_i,
    input wire logic cfg_win_en_i,
    input wire logic [2:0] cfg_route_i,
    input wire logic [1:0] cfg_pwm_bits_i,
    input wire logic [15:0] cfg_pwm_div_i,
    input wire logic [1:0] cfg_vstep_i,
    input wire logic [1:0][14:0] cfg_thr_i,
    input wire logic [1:0][14:0] cfg_hys_i,
    input wire logic [1:0] cfg_dir_i,
    input wire logic cfg_window_i,
    input wire logic [1:0][7:0] cfg_on_dly_i,
    input wire logic [1:0][7:0] cfg_off_dly_i,
    // Measurement results
    input wire logic [14:0] res_bridge_i,
    input wire logic [14:0] res_t1_i,
    input wire logic [14:0] res_t2_i,
    input wire logic [2:0] res_vld_i,
    // Serial interface and controller
    input wire logic ow_req_i,
    input wire logic ow_release_i,
    input wire logic spi_sdo_i,
    input wire logic cpu_alive_i,
    // Error sources
    input wire logic [1:0] wire_low_i,
    input wire logic cm_fault_i,
    input wire logic ram_err_i,
    input wire logic rom_err_i,
    input wire logic nvm_err_i,
    input wire logic reg_par_err_i,
    input wire logic sig_err_i,
    // Pins
    input wire logic multi_pin_b_i,
    output logic out_pin_o,
    output logic out_pin_oe_o,
    output logic out_analog_en_o,
    output logic multi_pin_a_o,
    output logic multi_pin_a_oe_o,
    output logic multi_pin_b_o,
    output logic multi_pin_b_oe_o,
    // Converter, interface and status
    output logic [10:0] dac_code_o,
    output logic [1:0] if_sel_o,
    output logic spi_sel_o,
    output logic [1:0] vstep_o,
    output logic diag_o,
    output logic diag_hi_o,
    output logic [7:0] err_code_o,
    output logic ctrl_err_o
);
    if (START_WIN_CYC < 1 || START_WIN_CYC >= (1 << 23))
        $error("START_WIN_CYC out of range");
    if (WDOG_CYC < 2 || WDOG_CYC >= (1 << 24))
        $error("WDOG_CYC out of range");

    // ==========================================================
    // Decoding
    function automatic sor_pkg::sor_pin_s pin_map(input logic [4:0] n);
        sor_pkg::sor_pin_s p;
        logic [4:0] k;
        p = '0;
        k = 5'h00;
        if (n != 5'h00 && n <= `SOR_CFG_I2C_LAST) begin
            p.o_sel = n >= `SOR_CFG_I2C_PLS ? sor_pkg::SOR_PLS :
                      n >= `SOR_CFG_I2C_ANA ? sor_pkg::SOR_ANA :
                      sor_pkg::SOR_NONE;
            k = n - (n >= `SOR_CFG_I2C_PLS ? `SOR_CFG_I2C_PLS :
                     n >= `SOR_CFG_I2C_ANA ? `SOR_CFG_I2C_ANA : 5'h01);
            p.a_sel = (k == 5'h01 || k == 5'h03) ? sor_pkg::SOR_ALM :
                      k >= 5'h04 ? sor_pkg::SOR_PLS : sor_pkg::SOR_NONE;
            p.b_alm = k == 5'h02 || k == 5'h03 || k == 5'h05;
        end else if (n >= `SOR_CFG_SPI_FIRST && n <= `SOR_CFG_SPI_LAST) begin
            p.spi = 1'b1;
            p.o_sel = n >= `SOR_CFG_SPI_PLS ? sor_pkg::SOR_PLS :
                      n >= `SOR_CFG_SPI_ANA ? sor_pkg::SOR_ANA :
                      sor_pkg::SOR_NONE;
            k = n - (n >= `SOR_CFG_SPI_PLS ? `SOR_CFG_SPI_PLS :
                     n >= `SOR_CFG_SPI_ANA ? `SOR_CFG_SPI_ANA :
                     `SOR_CFG_SPI_FIRST);
            p.a_sel = k == 5'h01 ? sor_pkg::SOR_ALM :
                      k == 5'h02 ? sor_pkg::SOR_PLS : sor_pkg::SOR_NONE;
        end
        return p;
    endfunction

    function automatic logic [1:0] src_idx(input logic [2:0] m,
                                           input logic hi);
        src_idx = 2'h3;
        for (int i = 0; i < 3; i++) begin
            if (m[i] && (hi || src_idx == 2'h3))
                src_idx = 2'(i);
        end
    endfunction

    function automatic logic pwm_lvl(input logic [14:0] r,
                                     input logic [11:0] cnt,
                                     input logic [1:0] bits);
        logic [11:0] v;
        v = 12'(r >> (3'h6 - {1'b0, bits}));
        return cnt < v;
    endfunction

    // ==========================================================
    // State
    sor_pkg::sor_state_s st_r;
    sor_pkg::sor_state_s st_nxt;
    sor_pkg::sor_pin_s pm;
    logic cs_act;
    logic tick;
    logic want;
    logic on_c;
    logic off_c;
    logic [1:0] dac_i;
    logic [1:0] pa_i;
    logic [1:0] pb_i;
    logic [14:0] dac_res;
    logic [15:0] v;
    logic [15:0] t;
    logic [15:0] h;
    logic [15:0] lo;
    logic [15:0] div_lim;
    logic [11:0] pmask;

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        pm = pin_map(cfg_num_i);
        want = 1'b0;
        on_c = 1'b0;
        off_c = 1'b0;
        v = {1'b0, res_bridge_i};
        t = 16'h0000;
        h = 16'h0000;
        lo = 16'h0000;
        cs_act = st_r.st == sor_pkg::SOR_RUN && pm.spi && !st_r.ss2;
        dac_i = src_idx(~cfg_route_i, 1'b0);
        pb_i = src_idx(cfg_route_i, 1'b0);
        pa_i = src_idx(cfg_route_i, 1'b1);
        dac_res = dac_i == 2'h3 ? 15'h0000 : st_r.res[dac_i];
        div_lim = cfg_pwm_div_i < 16'(`SOR_PWM_DIV_MIN) ?
                  16'(`SOR_PWM_DIV_MIN) : cfg_pwm_div_i;
        pmask = 12'hfff >> (2'h3 - cfg_pwm_bits_i);
        tick = st_r.div >= div_lim - 16'h0001;

        // Synchronisers
        st_nxt.w1 = wire_low_i;
        st_nxt.w2 = st_r.w1;
        st_nxt.ss1 = multi_pin_b_i;
        st_nxt.ss2 = st_r.ss1;
        st_nxt.cs = cs_act;

        // Start window
        case (st_r.st)
            sor_pkg::SOR_WIN: begin
                st_nxt.win = st_r.win + 23'h000001;
                if (!cfg_win_en_i)
                    st_nxt.st = sor_pkg::SOR_RUN;
                else if (ow_req_i)
                    st_nxt.st = sor_pkg::SOR_ONEW;
                else if (st_r.win == 23'(START_WIN_CYC - 1))
                    st_nxt.st = sor_pkg::SOR_RUN;
            end
            sor_pkg::SOR_ONEW: begin
                if (ow_release_i)
                    st_nxt.st = sor_pkg::SOR_RUN;
            end
            sor_pkg::SOR_RUN: st_nxt.st = sor_pkg::SOR_RUN;
            default: st_nxt.st = sor_pkg::SOR_WIN;
        endcase
        st_nxt.ifs = st_r.st != sor_pkg::SOR_RUN ? sor_pkg::SOR_IF_ONEW :
                     pm.spi ? sor_pkg::SOR_IF_SPI : sor_pkg::SOR_IF_I2C;

        // Result registers
        if (res_vld_i[0])
            st_nxt.res[0] = res_bridge_i;
        if (res_vld_i[1])
            st_nxt.res[1] = res_t1_i;
        if (res_vld_i[2])
            st_nxt.res[2] = res_t2_i;

        // Pulse generator
        st_nxt.div = tick ? 16'h0000 : st_r.div + 16'h0001;
        if (tick)
            st_nxt.pcnt = (st_r.pcnt & pmask) == pmask ? 12'h000 :
                          (st_r.pcnt & pmask) + 12'h001;
        st_nxt.pwm_a = pa_i != 2'h3 &&
                       pwm_lvl(st_r.res[pa_i], st_r.pcnt, cfg_pwm_bits_i);
        st_nxt.pwm_b = pb_i != 2'h3 &&
                       pwm_lvl(st_r.res[pb_i], st_r.pcnt, cfg_pwm_bits_i);

        // Alarm channels, bridge result only
        for (int c = 0; c < 2; c++) begin
            t = {1'b0, cfg_thr_i[c]};
            h = {1'b0, cfg_hys_i[c]};
            lo = {1'b0, cfg_thr_i[1]};
            if (c == 0 && cfg_window_i) begin
                on_c = v >= lo && v <= t;
                off_c = v + h < lo || v > t + h;
            end else if (cfg_dir_i[c]) begin
                on_c = v < t;
                off_c = v > t + h;
            end else begin
                on_c = v > t;
                off_c = v + h < t;
            end
            want = st_r.alm[c] ? !off_c : on_c;
            if (res_vld_i[0]) begin
                if (want == st_r.alm[c]) begin
                    st_nxt.dly[c] = 8'h00;
                end else if (st_r.dly[c] >= (want ? cfg_on_dly_i[c] :
                                            cfg_off_dly_i[c])) begin
                    st_nxt.alm[c] = want;
                    st_nxt.dly[c] = 8'h00;
                end else begin
                    st_nxt.dly[c] = st_r.dly[c] + 8'h01;
                end
            end
        end

        // Watchdog
        if (cpu_alive_i)
            st_nxt.alive = 1'b1;
        if (res_vld_i[0] && (st_r.alive || cpu_alive_i)) begin
            st_nxt.wd = 24'h000000;
            st_nxt.alive = 1'b0;
        end else if (st_r.wd != 24'(WDOG_CYC - 1)) begin
            st_nxt.wd = st_r.wd + 24'h000001;
        end

        // Error detection
        if (sig_err_i || reg_par_err_i)
            st_nxt.ctrl_err = 1'b1;
        if (!st_r.diag) begin
            st_nxt.diag = 1'b1;
            st_nxt.diag_hi = 1'b0;
            if (|st_r.w2) begin
                st_nxt.code = `SOR_ERR_WIRE;
                st_nxt.diag_hi = 1'b1;
            end else if (cm_fault_i) begin
                st_nxt.code = `SOR_ERR_CMODE;
                st_nxt.diag_hi = 1'b1;
            end else if (st_r.wd == 24'(WDOG_CYC - 1))
                st_nxt.code = `SOR_ERR_WDOG;
            else if (ram_err_i)
                st_nxt.code = `SOR_ERR_RAM;
            else if (rom_err_i)
                st_nxt.code = `SOR_ERR_ROM;
            else if (nvm_err_i)
                st_nxt.code = `SOR_ERR_NVM;
            else if (reg_par_err_i)
                st_nxt.code = `SOR_ERR_PAR;
            else if (sig_err_i)
                st_nxt.code = `SOR_ERR_SIG;
            else
                st_nxt.diag = 1'b0;
        end

        // DAC and regulator
        st_nxt.dac = st_r.diag ? (st_r.diag_hi ? `SOR_DAC_HI : `SOR_DAC_LO)
                     : dac_res[14:4];
        st_nxt.vstep = cfg_vstep_i;

        // OUT pin
        st_nxt.out = 1'b0;
        st_nxt.out_oe = 1'b0;
        st_nxt.out_ana = 1'b0;
        if (st_r.st == sor_pkg::SOR_RUN) begin
            if (pm.o_sel == sor_pkg::SOR_ANA) begin
                st_nxt.out_ana = 1'b1;
            end else if (pm.o_sel == sor_pkg::SOR_PLS) begin
                st_nxt.out_oe = 1'b1;
                if (cs_act)
                    st_nxt.out = 1'b0;
                else if (st_r.diag)
                    st_nxt.out = st_r.diag_hi;
                else
                    st_nxt.out = st_r.pwm_b;
            end
        end

        // Multi-function pins
        st_nxt.a = 1'b0;
        st_nxt.a_oe = 1'b0;
        st_nxt.b = 1'b0;
        st_nxt.b_oe = 1'b0;
        if (st_r.st == sor_pkg::SOR_RUN) begin
            if (cs_act) begin
                st_nxt.a = spi_sdo_i;
                st_nxt.a_oe = 1'b1;
            end else if (pm.a_sel == sor_pkg::SOR_ALM) begin
                st_nxt.a = st_r.alm[0];
                st_nxt.a_oe = 1'b1;
            end else if (pm.a_sel == sor_pkg::SOR_PLS) begin
                st_nxt.a = st_r.diag ? st_r.diag_hi : st_r.pwm_a;
                st_nxt.a_oe = 1'b1;
            end
            if (!pm.spi && pm.b_alm) begin
                st_nxt.b = st_r.alm[1];
                st_nxt.b_oe = 1'b1;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.ss1 <= `SOR_SS_IDLE;
            st_r.ss2 <= `SOR_SS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_pin_o = st_r.out;
    assign out_pin_oe_o = st_r.out_oe;
    assign out_analog_en_o = st_r.out_ana;
    assign multi_pin_a_o = st_r.a;
    assign multi_pin_a_oe_o = st_r.a_oe;
    assign multi_pin_b_o = st_r.b;
    assign multi_pin_b_oe_o = st_r.b_oe;
    assign dac_code_o = st_r.dac;
    assign if_sel_o = st_r.ifs;
    assign spi_sel_o = st_r.cs;
    assign vstep_o = st_r.vstep;
    assign diag_o = st_r.diag;
    assign diag_hi_o = st_r.diag_hi;
    assign err_code_o = st_r.code;
    assign ctrl_err_o = st_r.ctrl_err;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence s_wire_low;
        wire_low_i[0] [*3];
    endsequence
    sequence s_share_cs;
        cs_act && pm.o_sel == sor_pkg::SOR_PLS;
    endsequence

    a_alarm_cause: assert property (
        $changed(st_r.alm) |-> $past(res_vld_i[0]))
        else $error("alarm moved without bridge update");
    a_spi_no_b: assert property (
        $past(pm.spi) |-> !multi_pin_b_oe_o)
        else $error("pin b driven in SPI");
    a_i2c_pin_b: assert property (
        !pm.spi && pm.b_alm && st_r.st == sor_pkg::SOR_RUN
        |=> multi_pin_b_oe_o && multi_pin_b_o == $past(st_r.alm[1]))
        else $error("pin b not limit flag b");
    a_spi_sdo: assert property (
        cs_act |=> multi_pin_a_oe_o && multi_pin_a_o == $past(spi_sdo_i))
        else $error("pin a not data out");
    a_dac_top_bits: assert property (
        !st_r.diag |=> dac_code_o == $past(dac_res[14:4]))
        else $error("dac code not upper bits");
    a_pwm_suspend: assert property (
        s_share_cs |=> out_pin_oe_o && !out_pin_o)
        else $error("pulse not suspended");
    a_pwm_resume: assert property (
        $past(cs_act) && !cs_act && !st_r.diag &&
        pm.o_sel == sor_pkg::SOR_PLS |=> out_pin_o == $past(st_r.pwm_b))
        else $error("pulse not resumed");
    a_onewire_hold: assert property (
        st_r.st == sor_pkg::SOR_ONEW && !ow_release_i
        |=> st_r.st == sor_pkg::SOR_ONEW)
        else $error("left one-wire mode");
    a_window_end: assert property (
        st_r.st == sor_pkg::SOR_WIN && !ow_req_i &&
        st_r.win == 23'(START_WIN_CYC - 1) |=> st_r.st == sor_pkg::SOR_RUN)
        else $error("start window did not end");
    a_diag_rail: assert property (
        st_r.diag |=> diag_o ##0 dac_code_o ==
        ($past(st_r.diag_hi) ? `SOR_DAC_HI : `SOR_DAC_LO))
        else $error("diagnostic rail wrong");
    a_wire_break: assert property (
        s_wire_low |-> ##[1:3] diag_o)
        else $error("wire break not flagged");
    a_ctrl_err: assert property (
        sig_err_i |=> ctrl_err_o ##0 diag_o)
        else $error("controller error not flagged");
endmodule
`default_nettype wire

// ===== common/sor_consts.svh
// Constants for the sensor output stage routing block
`ifndef SOR_CONSTS_SVH
`define SOR_CONSTS_SVH
`define SOR_CLK_HZ 125000000
`define SOR_START_WIN_MS 20
`define SOR_START_WIN_CYC (`SOR_START_WIN_MS * (`SOR_CLK_HZ / 1000))
`define SOR_WDOG_MS 10
`define SOR_WDOG_CYC (`SOR_WDOG_MS * (`SOR_CLK_HZ / 1000))
`define SOR_PWM_MAX_HZ 4000
`define SOR_PWM_DIV_MIN ((`SOR_CLK_HZ + (`SOR_PWM_MAX_HZ << 9) - 1) / (`SOR_PWM_MAX_HZ << 9))
`define SOR_DAC_HI 11'h7ff
`define SOR_DAC_LO 11'h000
`define SOR_SS_IDLE 1'b1
`define SOR_CFG_I2C_ANA 5'h07
`define SOR_CFG_I2C_PLS 5'h0d
`define SOR_CFG_I2C_LAST 5'h12
`define SOR_CFG_SPI_FIRST 5'h13
`define SOR_CFG_SPI_ANA 5'h16
`define SOR_CFG_SPI_PLS 5'h19
`define SOR_CFG_SPI_LAST 5'h1b
`define SOR_ERR_WIRE 8'h01
`define SOR_ERR_CMODE 8'h02
`define SOR_ERR_WDOG 8'h03
`define SOR_ERR_RAM 8'h04
`define SOR_ERR_ROM 8'h05
`define SOR_ERR_NVM 8'h06
`define SOR_ERR_PAR 8'h07
`define SOR_ERR_SIG 8'h08
`endif

// ===== common/sor_pkg.sv
// Types for the sensor output stage routing block
package sor_pkg;
    typedef enum logic [1:0] {
        SOR_WIN = 2'b00, SOR_ONEW = 2'b01, SOR_RUN = 2'b10
    } sor_state_e;
    typedef enum logic [1:0] {
        SOR_NONE = 2'b00, SOR_ALM = 2'b01, SOR_PLS = 2'b10, SOR_ANA = 2'b11
    } sor_sel_e;
    typedef enum logic [1:0] {
        SOR_IF_ONEW = 2'b00, SOR_IF_I2C = 2'b01, SOR_IF_SPI = 2'b10
    } sor_if_e;
    typedef struct packed {
        logic spi;
        sor_sel_e o_sel;
        sor_sel_e a_sel;
        logic b_alm;
    } sor_pin_s;
    typedef struct packed {
        sor_state_e st;
        logic [22:0] win;
        logic [2:0][14:0] res;
        logic [15:0] div;
        logic [11:0] pcnt;
        logic pwm_a;
        logic pwm_b;
        logic [1:0] alm;
        logic [1:0][7:0] dly;
        logic [23:0] wd;
        logic alive;
        logic [1:0] w1;
        logic [1:0] w2;
        logic ss1;
        logic ss2;
        logic diag;
        logic diag_hi;
        logic ctrl_err;
        logic [7:0] code;
        logic out;
        logic out_oe;
        logic out_ana;
        logic a;
        logic a_oe;
        logic b;
        logic b_oe;
        logic cs;
        logic [10:0] dac;
        sor_if_e ifs;
        logic [1:0] vstep;
    } sor_state_s;
endpackage

// ===== test/sor_host_model.sv
// Host controller model on the serial side of the output stage
`timescale 1ns/1ps
`default_nettype none
module sor_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Serial lines
    output logic ow_req_o,
    output logic ow_release_o,
    output logic ss_n_o,
    output logic sdo_o
);
    logic in_frame = 1'b0;
    logic frame_bit = 1'b0;
    initial begin
        ow_req_o = 1'b0;
        ow_release_o = 1'b0;
        ss_n_o = 1'b1;
        sdo_o = 1'b0;
    end
    // Data toggles each cycle outside frames
    always @(negedge clk_sys_i) begin
        sdo_o <= in_frame ? frame_bit : ~sdo_o;
    end
    // One-wire request or release as a one-cycle pulse
    task automatic ow_pulse(input logic rel);
        @(negedge clk_sys_i);
        {ow_release_o, ow_req_o} = {rel, ~rel};
        @(negedge clk_sys_i);
        {ow_release_o, ow_req_o} = 2'b00;
    endtask
    // Select low for n cycles with a fixed data bit
    task automatic spi_frame(input int n, input logic b);
        in_frame = 1'b1;
        frame_bit = b;
        ss_n_o = 1'b0;
        repeat (n) @(negedge clk_sys_i);
        ss_n_o = 1'b1;
        in_frame = 1'b0;
        // Idle cycle so a following frame sees select rise
        @(negedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// ===== test/sor_output_stage_test.sv
// Self-checking bench for the output stage routing block
`timescale 1ns/1ps
`default_nettype none
`include "sor_consts.svh"
module sor_output_stage_test;
    localparam int WIN = 50;
    localparam int WDG = 200;
    localparam logic [7:0] CODES [8] = '{`SOR_ERR_WIRE, `SOR_ERR_WIRE,
        `SOR_ERR_CMODE, `SOR_ERR_RAM, `SOR_ERR_ROM, `SOR_ERR_NVM,
        `SOR_ERR_PAR, `SOR_ERR_SIG};
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [4:0] cfg_num = 5'h00;
    logic cfg_win_en = 1'b1;
    logic [2:0] cfg_route = 3'h0;
    logic [1:0] cfg_vstep = 2'h0;
    logic [1:0][14:0] cfg_thr = '0;
    logic [1:0] cfg_dir = 2'h0;
    logic [1:0][14:0] cfg_hys = '0;
    logic cfg_window = 1'b0;
    logic [1:0][7:0] cfg_on_dly = '0;
    logic [1:0][7:0] cfg_off_dly = '0;
    logic [2:0][14:0] res = '0;
    logic [2:0] res_vld = 3'h0;
    logic alive = 1'b0;
    logic hb_on = 1'b1;
    logic busy = 1'b0;
    logic [7:0] err_v = 8'h00;
    wire logic ow_req, ow_rel, ss_n, sdo;
    logic out_pin, out_oe, out_ana, pa, pa_oe, pb, pb_oe, spi_sel;
    logic diag, diag_hi, ctrl_err;
    logic [10:0] dac;
    logic [1:0] if_sel, vstep;
    logic [7:0] code;
    int mismatches = 0;
    int checks_done = 0;
    // ==========================================================
    // Clock, heartbeat and instances
    always #4 clk_sys_i = ~clk_sys_i;
    always begin
        repeat (40) @(negedge clk_sys_i);
        if (hb_on && !busy) begin
            alive = 1'b1;
            @(negedge clk_sys_i);
            alive = 1'b0;
            res_vld[0] = 1'b1;
            @(negedge clk_sys_i);
            res_vld[0] = 1'b0;
        end
    end
    sor_host_model host (.clk_sys_i(clk_sys_i), .ow_req_o(ow_req),
        .ow_release_o(ow_rel), .ss_n_o(ss_n), .sdo_o(sdo));
    sor_output_stage #(.START_WIN_CYC(WIN), .WDOG_CYC(WDG)) DUT (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_num_i(cfg_num),
        .cfg_win_en_i(cfg_win_en), .cfg_route_i(cfg_route),
        .cfg_pwm_bits_i(2'h0), .cfg_pwm_div_i(16'h003e),
        .cfg_vstep_i(cfg_vstep), .cfg_thr_i(cfg_thr), .cfg_hys_i(cfg_hys),
        .cfg_dir_i(cfg_dir), .cfg_window_i(cfg_window),
        .cfg_on_dly_i(cfg_on_dly), .cfg_off_dly_i(cfg_off_dly),
        .res_bridge_i(res[0]), .res_t1_i(res[1]),
        .res_t2_i(res[2]), .res_vld_i(res_vld), .ow_req_i(ow_req),
        .ow_release_i(ow_rel), .spi_sdo_i(sdo), .cpu_alive_i(alive),
        .wire_low_i(err_v[1:0]), .cm_fault_i(err_v[2]),
        .ram_err_i(err_v[3]), .rom_err_i(err_v[4]), .nvm_err_i(err_v[5]),
        .reg_par_err_i(err_v[6]), .sig_err_i(err_v[7]),
        .multi_pin_b_i(ss_n), .out_pin_o(out_pin), .out_pin_oe_o(out_oe),
        .out_analog_en_o(out_ana), .multi_pin_a_o(pa),
        .multi_pin_a_oe_o(pa_oe), .multi_pin_b_o(pb),
        .multi_pin_b_oe_o(pb_oe), .dac_code_o(dac), .if_sel_o(if_sel),
        .spi_sel_o(spi_sel), .vstep_o(vstep), .diag_o(diag),
        .diag_hi_o(diag_hi), .err_code_o(code), .ctrl_err_o(ctrl_err));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic start(input logic [4:0] num, input logic w, input int n);
        cfg_num = num;
        cfg_win_en = w;
        err_v = 8'h00;
        reset_i = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        chk(if_sel === 2'h0 && diag === 1'b0 && dac === 11'h000, "reset");
        reset_i = 1'b0;
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic load(input int i, input logic [14:0] v);
        busy = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        res[i] = v;
        res_vld[i] = 1'b1;
        @(negedge clk_sys_i);
        res_vld[i] = 1'b0;
        busy = 1'b0;
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic close_out();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_window();
        start(`SOR_CFG_I2C_ANA, 1'b1, WIN - 5);
        chk(if_sel === sor_pkg::SOR_IF_ONEW, "window mode");
        repeat (10) @(negedge clk_sys_i);
        chk(if_sel === sor_pkg::SOR_IF_I2C && out_ana === 1'b1,
            "run");
        start(`SOR_CFG_I2C_ANA, 1'b0, 4);
        chk(if_sel === sor_pkg::SOR_IF_I2C, "window skipped");
        start(`SOR_CFG_SPI_ANA, 1'b0, 4);
        chk(if_sel === sor_pkg::SOR_IF_SPI, "spi chosen");
        start(`SOR_CFG_I2C_LAST, 1'b0, 4);
        chk({out_oe, pa_oe, pb_oe, out_ana} === 4'b1110, "i2c pins");
        start(5'h15, 1'b0, 4);
        chk({out_oe, pa_oe, pb_oe, out_ana} === 4'b0100,
            "spi run pins");
    endtask
    task automatic t_onewire();
        start(`SOR_CFG_I2C_ANA, 1'b1, 10);
        host.ow_pulse(1'b0);
        repeat (WIN + 20) @(negedge clk_sys_i);
        chk(if_sel === sor_pkg::SOR_IF_ONEW, "one-wire held");
        host.ow_pulse(1'b1);
        repeat (5) @(negedge clk_sys_i);
        chk(if_sel === sor_pkg::SOR_IF_I2C, "released");
        host.ow_pulse(1'b0);
        repeat (5) @(negedge clk_sys_i);
        chk(if_sel === sor_pkg::SOR_IF_I2C, "late request");
    endtask
    task automatic t_route();
        cfg_route = 3'b110;
        start(`SOR_CFG_I2C_ANA, 1'b0, 4);
        load(0, 15'h5a5a);
        chk(dac === 11'h5a5 && pa_oe === 1'b0, "upper bits");
        cfg_route = 3'b101;
        start(`SOR_CFG_I2C_ANA, 1'b0, 4);
        load(1, 15'h7ff0);
        load(0, 15'h0010);
        chk(dac === 11'h7ff, "temp one to dac");
    endtask
    task automatic t_alarm();
        cfg_thr = {15'h1000, 15'h1000};
        cfg_dir = 2'b10;
        start(5'h04, 1'b0, 4);
        load(1, 15'h7fff);
        load(2, 15'h7fff);
        chk(pa === 1'b0 && pa_oe === 1'b1, "temperature ignored");
        load(0, 15'h2000);
        chk(pa === 1'b1 && pb === 1'b0 && pb_oe === 1'b1,
            "above");
        load(0, 15'h0800);
        chk(pa === 1'b0 && pb === 1'b1, "below");
        // Hysteresis and delays, no heartbeat updates in between
        hb_on = 1'b0;
        cfg_hys = {15'h0100, 15'h0100};
        cfg_on_dly = {8'h00, 8'h02};
        cfg_off_dly = {8'h01, 8'h00};
        start(5'h04, 1'b0, 4);
        load(0, 15'h1100);
        load(0, 15'h1100);
        chk(pa === 1'b0, "on delay");
        load(0, 15'h1100);
        chk(pa === 1'b1, "on after delay");
        load(0, 15'h0f80);
        chk(pa === 1'b1 && pb === 1'b1, "hysteresis a");
        load(0, 15'h0e00);
        load(0, 15'h1080);
        chk(pa === 1'b0 && pb === 1'b1, "hysteresis b");
        load(0, 15'h1200);
        chk(pa === 1'b0 && pb === 1'b1, "off delay");
        load(0, 15'h1200);
        chk(pa === 1'b1 && pb === 1'b0, "after delays");
        // Window mode on channel 0 between the two thresholds
        cfg_window = 1'b1;
        cfg_hys = '0;
        cfg_on_dly = '0;
        cfg_off_dly = '0;
        cfg_thr = {15'h0800, 15'h1000};
        start(5'h04, 1'b0, 4);
        load(0, 15'h0c00);
        chk(pa === 1'b1 && pb === 1'b0, "inside window");
        load(0, 15'h1400);
        chk(pa === 1'b0, "above window");
        load(0, 15'h0400);
        chk(pa === 1'b0 && pb === 1'b1, "below window");
        cfg_window = 1'b0;
        hb_on = 1'b1;
    endtask
    task automatic t_spi();
        int hi;
        cfg_route = 3'b001;
        start(`SOR_CFG_SPI_PLS, 1'b0, 4);
        load(0, 15'h7fff);
        chk(pb_oe === 1'b0 && if_sel === sor_pkg::SOR_IF_SPI,
            "select");
        for (int b = 0; b < 2; b++) begin
            fork
                host.spi_frame(12, b[0]);
                begin
                    repeat (8) @(negedge clk_sys_i);
                    chk(spi_sel === 1'b1 && pa === b[0], "sdo");
                    chk(out_pin === 1'b0 && out_oe === 1'b1,
                        "pulse suspended");
                end
            join
        end
        repeat (6) @(negedge clk_sys_i);
        chk(spi_sel === 1'b0 && out_oe === 1'b1,
            "selection ended");
        load(0, 15'h4000);
        hi = 0;
        repeat (512 * 62) begin
            @(negedge clk_sys_i);
            hi += (out_pin === 1'b1);
        end
        chk(hi == 256 * 62, "duty cycle");
    endtask
    task automatic t_errors();
        for (int i = 0; i < 8; i++) begin
            cfg_vstep = i[1:0];
            start(`SOR_CFG_I2C_ANA, 1'b0, 4);
            chk(vstep === cfg_vstep, "regulator step");
            err_v[i] = 1'b1;
            repeat (6) @(negedge clk_sys_i);
            chk(diag === 1'b1 && code === CODES[i],
                "code");
            chk(diag_hi === (i < 3) && dac === (i < 3 ? `SOR_DAC_HI
                : `SOR_DAC_LO), "rail");
            chk(ctrl_err === (i > 5), "controller flag");
        end
        start(`SOR_CFG_I2C_ANA, 1'b0, WDG * 2);
        chk(diag === 1'b0, "heartbeat kept");
        hb_on = 1'b0;
        repeat (WDG * 2 + 20) @(negedge clk_sys_i);
        chk(diag === 1'b1 && code === `SOR_ERR_WDOG, "watchdog");
        hb_on = 1'b1;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(negedge clk_sys_i);
        t_window();
        t_onewire();
        t_route();
        t_alarm();
        t_spi();
        t_errors();
        close_out();
    end
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
